// *** hw/irc_codec.sv ***
// recognition-service frame codec: receive parser and transmit framer
// assumes a character receiver on ref_clk that flags parity per byte,
// and line timing logic that pulses rx_frame_end at frame end or timeout
`timescale 1ns/1ns
`include "irc_cfg.svh"

module irc_codec #(
    parameter logic SEQ_EN = 1'b1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic rx_char_valid,
    input wire irc_pkg::irc_rx_char_t rx_char,
    input wire logic rx_frame_end,
    output logic rx_frame_valid,
    output irc_pkg::irc_frame_t rx_frame,
    output logic rx_err_valid,
    output irc_pkg::irc_err_t rx_err,
    input wire logic tx_req_valid,
    output logic tx_req_ready,
    input wire irc_pkg::irc_frame_t tx_req,
    output logic tx_refused,
    output logic tx_byte_valid,
    input wire logic tx_byte_ready,
    output logic [7:0] tx_byte,
    output logic tx_busy
);
    import irc_pkg::*;

    // command byte legal in either half, operation 0 or 1 only
    function automatic logic cmd_ok(input logic [7:0] code);
        logic half_ok;
        half_ok = code[7:4] == `IRC_REQ_NIBBLE
            || code[7:4] == `IRC_RSP_NIBBLE;
        return half_ok && code[3:0] <= `IRC_OP_NOTIFY;
    endfunction

    // payload length within the service limit
    function automatic logic len_ok(input logic [15:0] len);
        return len <= `IRC_MAX_LEN;
    endfunction

    // build the single command byte from its halves
    function automatic logic [7:0] make_cmd(input logic is_resp,
                                            input logic [3:0] op);
        return {is_resp ? `IRC_RSP_NIBBLE : `IRC_REQ_NIBBLE, op};
    endfunction

    // ---------------- receive side ----------------
    irc_rx_state_t rx_state;
    irc_rx_state_t next_rx_state;
    irc_frame_t rx_work;
    irc_err_t rx_acc;
    irc_err_t rx_final;
    logic [7:0] rx_type_hi;
    logic [4:0] rx_idx;
    logic [7:0] rx_sum;
    logic [7:0] last_req_seq;

    // receive decode
    wire logic [7:0] rx_data = rx_char.data;
    wire logic rx_in_frame = rx_state != RX_IDLE;
    wire logic rx_hdr_hit = rx_char_valid && !rx_in_frame
        && rx_data == `IRC_HEADER_BYTE;
    wire logic rx_take = rx_char_valid && rx_in_frame && !rx_frame_end;
    wire logic rx_summed = rx_take && rx_state != RX_TAIL;
    wire logic [15:0] rx_len_now = {rx_work.len[15:8], rx_data};
    wire logic rx_len_bad = !len_ok(rx_len_now);
    wire logic rx_last_data = rx_idx == rx_work.len[4:0] - 5'h01;
    wire logic rx_complete = rx_state == RX_TAIL && !rx_acc.bad_len;
    wire logic rx_close = rx_frame_end && rx_in_frame;

    // verdict at frame end; a zero sum including the checksum is good
    assign rx_final.parity = rx_acc.parity;
    assign rx_final.bad_type = rx_acc.bad_type;
    assign rx_final.bad_cmd = rx_acc.bad_cmd;
    assign rx_final.bad_len = rx_acc.bad_len;
    assign rx_final.bad_sum = rx_complete && rx_sum != 8'h00;
    assign rx_final.truncated = rx_state != RX_TAIL;
    assign rx_final.overrun = rx_acc.overrun;
    wire logic rx_good = rx_final == '0;

    // sum of every byte after the header up to the checksum, checksum included
    irc_csum u_rx_sum (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clear(rx_hdr_hit),
        .add(rx_summed),
        .data(rx_data),
        .sum(rx_sum),
        .check()
    );

    // parser walks the fields in line order
    always_comb begin
        next_rx_state = rx_state;
        if (rx_close) begin
            next_rx_state = RX_IDLE;
        end else if (rx_hdr_hit) begin
            next_rx_state = RX_TYPE_HI;
        end else if (rx_take) begin
            case (rx_state)
                RX_TYPE_HI: next_rx_state = RX_TYPE_LO;
                RX_TYPE_LO: next_rx_state = RX_CMD;
                RX_CMD: next_rx_state = RX_SEQ;
                RX_SEQ: next_rx_state = RX_LEN_HI;
                RX_LEN_HI: next_rx_state = RX_LEN_LO;
                RX_LEN_LO: begin
                    if (rx_len_bad) begin
                        next_rx_state = RX_TAIL;
                    end else if (rx_len_now == 16'h0000) begin
                        next_rx_state = RX_CSUM;
                    end else begin
                        next_rx_state = RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_last_data) begin
                        next_rx_state = RX_CSUM;
                    end
                end
                RX_CSUM: next_rx_state = RX_TAIL;
                default: next_rx_state = rx_state;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rx_state <= RX_IDLE;
        end else begin
            rx_state <= next_rx_state;
        end
    end

    // field capture and error gathering while a frame is open
    always_ff @(posedge ref_clk) begin
        if (!resetn || rx_hdr_hit) begin
            rx_work <= '0;
            rx_acc <= '0;
            rx_type_hi <= 8'h00;
            rx_idx <= 5'h00;
        end else if (rx_take) begin
            rx_acc.parity <= rx_acc.parity | rx_char.parity_err;
            case (rx_state)
                RX_TYPE_HI: rx_type_hi <= rx_data;
                RX_TYPE_LO: begin
                    rx_acc.bad_type <= {rx_type_hi, rx_data}
                        != `IRC_FRAME_TYPE;
                end
                RX_CMD: begin
                    rx_work.is_resp <= rx_data[7:4] == `IRC_RSP_NIBBLE;
                    rx_work.op <= rx_data[3:0];
                    rx_acc.bad_cmd <= !cmd_ok(rx_data);
                end
                RX_SEQ: rx_work.seq <= rx_data;
                RX_LEN_HI: rx_work.len[15:8] <= rx_data;
                RX_LEN_LO: begin
                    rx_work.len[7:0] <= rx_data;
                    rx_acc.bad_len <= rx_len_bad;
                end
                RX_DATA: begin
                    rx_work.payload[rx_idx[3:0]] <= rx_data;
                    rx_idx <= rx_idx + 5'h01;
                end
                RX_TAIL: begin
                    // a byte past the checksum means the length lied
                    rx_acc.overrun <= rx_acc.overrun | !rx_acc.bad_len;
                end
                default: rx_idx <= rx_idx;
            endcase
        end
    end

    // hand good frames up, drop the rest with a reason
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rx_frame_valid <= 1'b0;
            rx_err_valid <= 1'b0;
            rx_frame <= '0;
            rx_err <= '0;
            last_req_seq <= `IRC_NO_SEQ;
        end else begin
            rx_frame_valid <= rx_close && rx_good;
            rx_err_valid <= rx_close && !rx_good;
            if (rx_close) begin
                rx_err <= rx_final;
            end
            if (rx_close && rx_good) begin
                rx_frame <= rx_work;
                if (!rx_work.is_resp) begin
                    last_req_seq <= rx_work.seq;
                end
            end
        end
    end

    // ---------------- transmit side ----------------
    irc_tx_state_t tx_state;
    irc_tx_state_t next_tx_state;
    irc_frame_t tx_work;
    logic [4:0] tx_idx;
    logic [7:0] tx_out;
    logic [7:0] tx_check;
    logic buf_in_ready;

    // request screening; reserved commands and long payloads refused
    wire logic tx_accept = tx_req_valid && tx_req_ready;
    wire logic tx_req_ok = cmd_ok(make_cmd(tx_req.is_resp, tx_req.op))
        && len_ok(tx_req.len);
    wire logic tx_start = tx_accept && tx_req_ok;
    wire logic [7:0] tx_seq_pick = !SEQ_EN ? `IRC_NO_SEQ
        : tx_req.is_resp ? last_req_seq
        : tx_req.seq;
    wire logic buf_in_valid = tx_state != TX_IDLE;
    wire logic tx_step = buf_in_valid && buf_in_ready;
    wire logic tx_summed = tx_step && tx_state != TX_HDR
        && tx_state != TX_CSUM;
    wire logic tx_last_data = tx_idx == tx_work.len[4:0] - 5'h01;
    assign tx_req_ready = tx_state == TX_IDLE;
    assign tx_busy = !tx_req_ready || tx_byte_valid;

    // byte on the line for each field
    always_comb begin
        case (tx_state)
            TX_HDR: tx_out = `IRC_HEADER_BYTE;
            TX_TYPE_HI: tx_out = 8'(`IRC_FRAME_TYPE >> 8);
            TX_TYPE_LO: tx_out = 8'(`IRC_FRAME_TYPE);
            TX_CMD: tx_out = make_cmd(tx_work.is_resp, tx_work.op);
            TX_SEQ: tx_out = tx_work.seq;
            TX_LEN_HI: tx_out = tx_work.len[15:8];
            TX_LEN_LO: tx_out = tx_work.len[7:0];
            TX_DATA: tx_out = tx_work.payload[tx_idx[3:0]];
            TX_CSUM: tx_out = tx_check;
            default: tx_out = 8'h00;
        endcase
    end

    // running sum of the bytes the framer has pushed after the header
    irc_csum u_tx_sum (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clear(tx_start),
        .add(tx_summed),
        .data(tx_out),
        .sum(),
        .check(tx_check)
    );

    // framer advances only when the buffer takes the byte
    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            TX_IDLE: begin
                if (tx_start) begin
                    next_tx_state = TX_HDR;
                end
            end
            TX_HDR: if (tx_step) next_tx_state = TX_TYPE_HI;
            TX_TYPE_HI: if (tx_step) next_tx_state = TX_TYPE_LO;
            TX_TYPE_LO: if (tx_step) next_tx_state = TX_CMD;
            TX_CMD: if (tx_step) next_tx_state = TX_SEQ;
            TX_SEQ: if (tx_step) next_tx_state = TX_LEN_HI;
            TX_LEN_HI: if (tx_step) next_tx_state = TX_LEN_LO;
            TX_LEN_LO: begin
                if (tx_step) begin
                    next_tx_state = (tx_work.len == 16'h0000)
                        ? TX_CSUM : TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_step && tx_last_data) begin
                    next_tx_state = TX_CSUM;
                end
            end
            TX_CSUM: if (tx_step) next_tx_state = TX_IDLE;
            default: next_tx_state = TX_IDLE;
        endcase
    end

    // request latch, payload index and refusal pulse
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tx_state <= TX_IDLE;
            tx_work <= '0;
            tx_idx <= 5'h00;
            tx_refused <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_refused <= tx_accept && !tx_req_ok;
            if (tx_start) begin
                tx_work <= tx_req;
                tx_work.seq <= tx_seq_pick;
                tx_idx <= 5'h00;
            end else if (tx_step && tx_state == TX_DATA) begin
                tx_idx <= tx_idx + 5'h01;
            end
        end
    end

    // two entries ride out a receiver stall without losing a byte
    irc_buf2 #(
        .WIDTH(8),
        .DEPTH(`IRC_BUF_DEPTH)
    ) u_tx_buf (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(tx_out),
        .out_valid(tx_byte_valid),
        .out_ready(tx_byte_ready),
        .out_data(tx_byte)
    );
endmodule

// *** hw/irc_cfg.svh ***
// constants of the recognition-service frame codec
// included by the package and by the codec; guarded
`ifndef IRC_CFG_SVH
`define IRC_CFG_SVH

// fixed field values
`define IRC_HEADER_BYTE 8'h02
`define IRC_FRAME_TYPE 16'hFFFF
`define IRC_NO_SEQ 8'h00

// command code halves and operations
`define IRC_REQ_NIBBLE 4'h0
`define IRC_RSP_NIBBLE 4'h8
`define IRC_OP_IFDATA 4'h0
`define IRC_OP_NOTIFY 4'h1

// payload limits
`define IRC_MAX_LEN 16'h0010
`define IRC_MAX_BYTES 16

// transmit byte buffer depth
`define IRC_BUF_DEPTH 2

`endif

// *** hw/irc_pkg.sv ***
// types shared by the recognition-service frame codec
// needs irc_cfg.svh on the include path
package irc_pkg;
`include "irc_cfg.svh"

    // receive parser states, gray along the usual path
    typedef enum logic [3:0] {
        RX_IDLE = 4'h0,
        RX_TYPE_HI = 4'h1,
        RX_TYPE_LO = 4'h3,
        RX_CMD = 4'h2,
        RX_SEQ = 4'h6,
        RX_LEN_HI = 4'h7,
        RX_LEN_LO = 4'h5,
        RX_DATA = 4'h4,
        RX_CSUM = 4'hC,
        RX_TAIL = 4'hD
    } irc_rx_state_t;

    // transmit framer states, gray along the usual path
    typedef enum logic [3:0] {
        TX_IDLE = 4'h0,
        TX_HDR = 4'h1,
        TX_TYPE_HI = 4'h3,
        TX_TYPE_LO = 4'h2,
        TX_CMD = 4'h6,
        TX_SEQ = 4'h7,
        TX_LEN_HI = 4'h5,
        TX_LEN_LO = 4'h4,
        TX_DATA = 4'hC,
        TX_CSUM = 4'hD
    } irc_tx_state_t;

    // payload bytes, element 0 is the first byte on the line
    typedef logic [`IRC_MAX_BYTES-1:0][7:0] irc_payload_t;

    // one received character with its parity verdict
    typedef struct packed {
        logic [7:0] data;
        logic parity_err;
    } irc_rx_char_t;

    // one frame as seen by the user side
    typedef struct packed {
        logic is_resp;
        logic [3:0] op;
        logic [7:0] seq;
        logic [15:0] len;
        irc_payload_t payload;
    } irc_frame_t;

    // reasons a received frame was dropped
    typedef struct packed {
        logic parity;
        logic bad_type;
        logic bad_cmd;
        logic bad_len;
        logic bad_sum;
        logic truncated;
        logic overrun;
    } irc_err_t;
endpackage

// *** hw/irc_csum.sv ***
// running modulo-256 byte sum with its two's complement
// assumes clear and add come from logic on ref_clk
`timescale 1ns/1ns

module irc_csum (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic add,
    input wire logic [7:0] data,
    output logic [7:0] sum,
    output logic [7:0] check
);
    import irc_pkg::*;

    // clear wins so a frame start never inherits an old byte
    always_ff @(posedge ref_clk) begin
        if (!resetn || clear) begin
            sum <= 8'h00;
        end else if (add) begin
            sum <= sum + data;
        end
    end

    // value that brings the sum back to zero
    assign check = 8'(~sum + 8'h01);
endmodule

// *** hw/irc_buf2.sv ***
// small flop fifo with valid and ready on both sides
// assumes both sides on ref_clk; depth of at least two
`timescale 1ns/1ns

module irc_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import irc_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [CW-1:0] count;

    // wrap an index at the depth, which need not be a power of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] i);
        return (i == AW'(DEPTH - 1)) ? '0 : AW'(i + 1'b1);
    endfunction

    // honest full and empty straight from the count
    assign in_ready = count != CW'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_idx];
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;

    // pointers and occupancy
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_idx <= bump(wr_idx);
            end
            if (pop) begin
                rd_idx <= bump(rd_idx);
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end

    // storage, cleared so the data output is defined from reset
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (push) begin
            mem[wr_idx] <= in_data;
        end
    end
endmodule

// *** sim/irc_codec_monitor.sv ***
// assertion checker bound to every frame codec
// sees only the codec's ports; one clock, reset synchronous active low
`timescale 1ns/1ns

module irc_codec_monitor (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic rx_char_valid,
    input wire irc_pkg::irc_rx_char_t rx_char,
    input wire logic rx_frame_end,
    input wire logic rx_frame_valid,
    input wire irc_pkg::irc_frame_t rx_frame,
    input wire logic rx_err_valid,
    input wire irc_pkg::irc_err_t rx_err,
    input wire logic tx_req_valid,
    input wire logic tx_req_ready,
    input wire irc_pkg::irc_frame_t tx_req,
    input wire logic tx_refused,
    input wire logic tx_byte_valid,
    input wire logic tx_byte_ready,
    input wire logic [7:0] tx_byte,
    input wire logic tx_busy
);
    import irc_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // a taken request either starts a frame or is refused
    wire take = tx_req_valid && tx_req_ready;
    wire take_bad = take && (tx_req.op > 4'h1 || tx_req.len > 16'h0010);
    wire take_ok = take && !take_bad;

    // header only shows first when nothing older waits in the buffer
    sequence s_start;
        take_ok && !tx_busy;
    endsequence
    sequence s_drained;
        s_start ##1 tx_byte_ready [*3];
    endsequence

    property p_tx_header;
        s_start |-> ##2 tx_byte_valid && tx_byte == 8'h02;
    endproperty
    a_tx_header: assert property (p_tx_header)
        else $error("frame does not open with the header byte");
    property p_tx_type;
        s_drained |-> tx_byte == 8'hFF ##1 tx_byte == 8'hFF;
    endproperty
    a_tx_type: assert property (p_tx_type)
        else $error("frame type bytes wrong");
    property p_take_busy;
        take_ok |=> !tx_req_ready;
    endproperty
    a_take_busy: assert property (p_take_busy)
        else $error("framer takes a request while framing");
    property p_refuse;
        take_bad |=> tx_refused && tx_req_ready;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("bad request not refused");
    property p_refuse_cause;
        tx_refused |-> $past(take_bad);
    endproperty
    a_refuse_cause: assert property (p_refuse_cause)
        else $error("refusal without a bad request");
    property p_rx_close;
        rx_frame_valid || rx_err_valid |->
            $past(rx_frame_end) && !(rx_frame_valid && rx_err_valid);
    endproperty
    a_rx_close: assert property (p_rx_close)
        else $error("frame verdict not one cycle after frame end");
    property p_rx_err;
        rx_err_valid |-> rx_err != '0 ##1 !rx_err_valid;
    endproperty
    a_rx_err: assert property (p_rx_err)
        else $error("drop without a cause or longer than a cycle");
    property p_rx_good;
        rx_frame_valid |-> rx_err == '0 && rx_frame.len <= 16'h0010;
    endproperty
    a_rx_good: assert property (p_rx_good)
        else $error("good frame with error or long length");
    // a stall by the far side must lose no byte
    property p_byte_hold;
        tx_byte_valid && !tx_byte_ready |=> tx_byte_valid && $stable(tx_byte);
    endproperty
    a_byte_hold: assert property (p_byte_hold)
        else $error("byte changed or lost during stall");
endmodule

bind irc_codec irc_codec_monitor u_mon (
    .ref_clk(ref_clk), .resetn(resetn), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_frame_end(rx_frame_end),
    .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
    .rx_err_valid(rx_err_valid), .rx_err(rx_err),
    .tx_req_valid(tx_req_valid), .tx_req_ready(tx_req_ready),
    .tx_req(tx_req), .tx_refused(tx_refused),
    .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .tx_byte(tx_byte), .tx_busy(tx_busy)
);

// *** sim/irc_line_model.sv ***
// far side of the serial line: sends characters, sinks framed bytes
// assumes the codec's ports on ref_clk; its tasks are run by the bench
`timescale 1ns/1ns

module irc_line_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic slow,
    output logic rx_char_valid,
    output irc_pkg::irc_rx_char_t rx_char,
    output logic rx_frame_end,
    input wire logic tx_byte_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_byte_ready
);
    import irc_pkg::*;
    logic [7:0] got[$];
    logic [1:0] tick;

    initial begin
        rx_char_valid = 1'b0;
        rx_char = '0;
        rx_frame_end = 1'b0;
    end

    // when slow, takes one byte in four so the buffer fills and waits
    assign tx_byte_ready = resetn && (!slow || tick == 2'h3);
    always @(posedge ref_clk) begin
        tick <= resetn ? tick + 2'h1 : 2'h0;
        if (tx_byte_valid && tx_byte_ready)
            got.push_back(tx_byte);
    end

    // frame as the far party forms it; payload counts up from 0x0a
    function automatic void mk(output logic [7:0] b[$],
        input logic [7:0] cmd, input logic [7:0] seq,
        input logic [15:0] dl, input int n);
        logic [7:0] s;
        b = {8'h02, 8'hFF, 8'hFF, cmd, seq, dl[15:8], dl[7:0]};
        for (int i = 0; i < n; i++)
            b.push_back(8'h0A + 8'(i));
        s = 8'h00;
        foreach (b[i])
            if (i > 0)
                s += b[i];
        b.push_back(-s);
    endfunction

    // one char per cycle, then the end pulse; perr marks a parity hit
    task automatic send(input logic [7:0] b[$], input int perr);
        foreach (b[i]) begin
            @(posedge ref_clk) #1;
            rx_char_valid = 1'b1;
            rx_char = '{data: b[i], parity_err: (i == perr)};
        end
        @(posedge ref_clk) #1;
        rx_char_valid = 1'b0;
        rx_char.data = ~rx_char.data; // idle line shows no stale byte
        rx_frame_end = 1'b1;
        @(posedge ref_clk) #1;
        rx_frame_end = 1'b0;
    endtask
endmodule

// *** sim/tb_irc_codec.sv ***
// self-checking bench for the frame codec
// assumes the codec under hw/ and the line model beside this file
`timescale 1ns/1ns

module tb_irc_codec;
    import irc_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic slow = 1'b0;
    logic rx_char_valid, rx_frame_end, rx_frame_valid, rx_err_valid;
    logic tx_req_valid, tx_req_ready, tx_refused, tx_busy;
    logic tx_byte_valid, tx_byte_ready;
    logic [7:0] tx_byte;
    irc_rx_char_t rx_char;
    irc_frame_t rx_frame, tx_req;
    irc_err_t rx_err;
    int err_count = 0;
    int compares = 0;

    // 250 MHz
    always #2 ref_clk = ~ref_clk;

    irc_codec u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .rx_frame_end(rx_frame_end),
        .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
        .rx_err_valid(rx_err_valid), .rx_err(rx_err),
        .tx_req_valid(tx_req_valid), .tx_req_ready(tx_req_ready),
        .tx_req(tx_req), .tx_refused(tx_refused),
        .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
        .tx_byte(tx_byte), .tx_busy(tx_busy)
    );
    irc_line_model u_far (
        .ref_clk(ref_clk), .resetn(resetn), .slow(slow),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_frame_end(rx_frame_end), .tx_byte_valid(tx_byte_valid),
        .tx_byte(tx_byte), .tx_byte_ready(tx_byte_ready)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic timeout(input string what);
        $display("ERROR %s expected done seen timeout", what);
        err_count++;
        report_and_stop();
    endtask

    // compares the line bytes the far side took against a built stream
    task automatic chk_q(input logic [7:0] exp[$]);
        chk("byte count", 16'(exp.size()), 16'(u_far.got.size()));
        foreach (exp[i])
            if (i < u_far.got.size())
                chk("line byte", 16'(exp[i]), 16'(u_far.got[i]));
        u_far.got.delete();
    endtask

    // leaves valid high so back-to-back requests never drop it between
    task automatic push(input irc_frame_t f);
        int n;
        n = 0;
        tx_req = f;
        tx_req_valid = 1'b1;
        while (tx_req_ready !== 1'b1 && n < 2000) begin
            @(posedge ref_clk) #1;
            n++;
        end
        if (n == 2000)
            timeout("request taken");
        @(posedge ref_clk) #1;
    endtask

    task automatic rx_bad(input logic [7:0] b[$], input int perr,
        input logic [6:0] want);
        u_far.send(b, perr);
        chk("drop flag", 16'h0001, 16'(rx_err_valid && !rx_frame_valid));
        chk("drop cause", 16'(want), 16'(rx_err & want));
    endtask

    // a stray byte before the header is ignored; 16 bytes is the limit
    task automatic t_rx_good();
        logic [7:0] b[$];
        u_far.mk(b, 8'h00, 8'h05, 16'h0000, 0);
        b.push_front(8'h55);
        u_far.send(b, -1);
        chk("req valid", 16'h0001, 16'(rx_frame_valid));
        chk("req cmd", 16'h0000, {11'h0, rx_frame.is_resp, rx_frame.op});
        chk("req seq", 16'h0005, 16'(rx_frame.seq));
        u_far.mk(b, 8'h81, 8'h05, 16'h0010, 16);
        u_far.send(b, -1);
        chk("rsp valid", 16'h0001, 16'(rx_frame_valid));
        chk("rsp cmd", 16'h0011, {11'h0, rx_frame.is_resp, rx_frame.op});
        chk("rsp len", 16'h0010, rx_frame.len);
        for (int i = 0; i < 16; i++)
            chk("rsp data", 16'(8'h0A + 8'(i)), 16'(rx_frame.payload[i]));
    endtask

    task automatic t_rx_bad();
        logic [7:0] b[$];
        for (int k = 0; k < 28; k++) begin
            u_far.mk(b, {k[0], 3'h0, 4'(k / 2 + 2)}, 8'h33, 16'h0000, 0);
            rx_bad(b, -1, 7'h10);
        end
        u_far.mk(b, 8'h00, 8'h33, 16'h0000, 0);
        b[$] = b[$] ^ 8'h01;
        rx_bad(b, -1, 7'h04);
        b[$] = b[$] ^ 8'h01;
        rx_bad(b, 4, 7'h40);
        b.pop_back();
        rx_bad(b, -1, 7'h02);
        u_far.mk(b, 8'h00, 8'h33, 16'h0000, 0);
        b.push_back(8'h00);
        rx_bad(b, -1, 7'h01);
        b.pop_back();
        b[2] = 8'hFE;
        b[$] = b[$] + 8'h01;
        rx_bad(b, -1, 7'h20);
        u_far.mk(b, 8'h80, 8'h33, 16'h0011, 17);
        rx_bad(b, -1, 7'h08);
    endtask

    // all four commands back to back, the far side stalling later on
    task automatic t_tx();
        irc_frame_t f;
        logic [7:0] one[$];
        logic [7:0] exp[$];
        for (int k = 0; k < 4; k++) begin
            f = '0;
            f.is_resp = k[1];
            f.op = 4'(k[0]);
            f.seq = 8'h37;
            f.len = 16'(k * 5 + 1);
            for (int i = 0; i < 16; i++)
                f.payload[i] = 8'h0A + 8'(i);
            slow = k[1];
            push(f);
            u_far.mk(one, {k[1], 3'h0, 4'(k[0])},
                k[1] ? 8'h05 : 8'h37, f.len, k * 5 + 1);
            exp = {exp, one};
        end
        tx_req_valid = 1'b0;
        for (int n = 0; tx_busy !== 1'b0; n++) begin
            if (n == 2000)
                timeout("frames sent");
            @(posedge ref_clk) #1;
        end
        slow = 1'b0;
        chk_q(exp);
    endtask

    task automatic t_tx_refuse();
        irc_frame_t f;
        f = '0;
        f.op = 4'h2;
        push(f);
        chk("refused cmd", 16'h0001, 16'(tx_refused));
        f.op = 4'h1;
        f.len = 16'h0011;
        push(f);
        chk("refused len", 16'h0001, 16'(tx_refused));
        tx_req_valid = 1'b0;
        repeat (4) @(posedge ref_clk) #1;
        chk("no bytes", 16'h0000, 16'(u_far.got.size()));
    endtask

    initial begin
        tx_req_valid = 1'b0;
        tx_req = '0;
        repeat (5) @(posedge ref_clk);
        #1 resetn = 1'b1;
        t_rx_good();
        t_rx_bad();
        t_tx();
        t_tx_refuse();
        report_and_stop();
    end
endmodule
